// >>> t2r_map.svh
// Purpose: Register offsets, field positions and reset values of the timer-2 register block
// Assumes: Data-space byte addresses on an 8-bit internal bus
// Notes:   Definitions only
`ifndef T2R_MAP_SVH
`define T2R_MAP_SVH

// ----------------------------------------
// Register offsets (data space)
// ----------------------------------------
`define T2R_OFS_FLAGS   8'h37
`define T2R_OFS_PSYNC   8'h43
`define T2R_OFS_MASK    8'h70
`define T2R_OFS_CTRL_A  8'hB0
`define T2R_OFS_CTRL_B  8'hB1
`define T2R_OFS_CNT     8'hB2
`define T2R_OFS_CMP_A   8'hB3
`define T2R_OFS_CMP_B   8'hB4
`define T2R_OFS_ASYNC   8'hB6
// Short I/O space: offset is data-space offset minus this base
`define T2R_IO_BASE     8'h20
`define T2R_IO_TOP      8'h3F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T2R_BIT_CMP_B   2
`define T2R_BIT_CMP_A   1
`define T2R_BIT_OVF     0
`define T2R_BIT_TSM     7
`define T2R_BIT_ASYNC_PRESCALER_RESET  1
`define T2R_BIT_SYNC_PRESCALER_RESET 0
`define T2R_BIT_EXT_CLOCK_IN_EN   6
`define T2R_BIT_AS      5
`define T2R_BIT_FOC_B   6
`define T2R_CTRL_A_MASK 8'hF3
`define T2R_CTRL_B_MASK 8'h0F

// ----------------------------------------
// Reset values and counter limits
// ----------------------------------------
`define T2R_RST_VAL     8'h00
`define T2R_MAX         8'hFF
`define T2R_BOTTOM      8'h00

`endif

// >>> t2r_pkg.sv
// Purpose: Types shared by the timer-2 register block
// Assumes: Nothing beyond SystemVerilog packed structs
// Notes:   Constants live in t2r_map.svh
package t2r_pkg;

    // CPU access to the register block, one cycle per access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       io_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } t2r_bus_req_type;

    // One bit per timer-2 interrupt source
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } t2r_irq_type;

    typedef enum logic {
        T2R_UP,
        T2R_DOWN
    } t2r_dir_type;

endpackage

// >>> t2r_flag_cell.sv
// Purpose: One sticky event flag, set by hardware, cleared by write-one or by acknowledge
// Assumes: All inputs on core_clk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module t2r_flag_cell (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag_q
);
    logic flag_d;

    // A clear in the event cycle must not lose the event
    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule
`default_nettype wire

// >>> t2r_hold_cell.sv
// Purpose: Holding register with update-busy bit for a register written across to the osc domain
// Assumes: commit is a one-cycle pulse at each oscillator tick
// Notes:   A capture in the commit cycle keeps busy set for the next tick
`timescale 1ns/1ps
`default_nettype none
module t2r_hold_cell #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             commit,
    output var  logic             busy_q,
    output var  logic [WIDTH-1:0] held_q,
    output var  logic             load
);
    logic             busy_d;
    logic [WIDTH-1:0] held_d;

    // Transfer only a value captured before this tick
    always_comb begin
        load   = busy_q && commit && !capture;
        busy_d = busy_q;
        held_d = held_q;
        if (load) begin
            busy_d = 1'b0;
        end
        if (capture) begin
            busy_d = 1'b1;
            held_d = wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            held_q <= '0;
        end else begin
            busy_q <= busy_d;
            held_q <= held_d;
        end
    end
endmodule
`default_nettype wire

// >>> t2r_timer2_regs.sv
// Purpose: Timer-2 register side: compare, mask, flags, async status, prescaler sync control
// Assumes: core_clk is the I/O clock; osc_input_pin is far slower and is sampled here
// Notes:   Prescaler and clock-select dividers sit outside; any non-zero select counts
`timescale 1ns/1ps
`default_nettype none
`include "t2r_map.svh"
module t2r_timer2_regs
    import t2r_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire t2r_bus_req_type bus_req,
    input  wire logic            gie,
    input  wire t2r_irq_type     irq_ack,
    input  wire logic            osc_input_pin,
    output var  logic [7:0]      bus_rdata_q,
    output var  t2r_irq_type     irq_req_q,
    output var  logic            compare_b_wave_pin_q,
    output var  logic            ext_clk_buf_en_q,
    output var  logic            xtal_osc_run_q,
    output var  logic            async_prescaler_reset_q,
    output var  logic            sync_prescaler_reset_q
);
    // ----------------------------------------
    // Oscillator sampling and tick
    // ----------------------------------------
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic osc_tick, tick;

    // Two stages before use; the first is read by the second only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_input_pin;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic [7:0] eff_addr;
    logic       io_ok;
    logic       wr_flags, wr_psync, wr_mask, wr_ctla, wr_ctlb;
    logic       wr_cnt, wr_cmpa, wr_cmpb, wr_async;
    logic [7:0] wd;

    // Short I/O form reaches only the low window of data space
    always_comb begin
        io_ok    = !bus_req.io_space || (bus_req.addr <= `T2R_IO_TOP);
        eff_addr = bus_req.io_space ? 8'(bus_req.addr + `T2R_IO_BASE) : bus_req.addr;
        wd       = bus_req.wdata;
        wr_flags = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_FLAGS);
        wr_psync = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_PSYNC);
        wr_mask  = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_MASK);
        wr_ctla  = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_CTRL_A);
        wr_ctlb  = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_CTRL_B);
        wr_cnt   = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_CNT);
        wr_cmpa  = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_CMP_A);
        wr_cmpb  = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_CMP_B);
        wr_async = bus_req.wr && io_ok && (eff_addr == `T2R_OFS_ASYNC);
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0]  cnt_q, cnt_d, cmpa_q, cmpa_d, cmpb_q, cmpb_d;
    logic [7:0]  ctla_q, ctla_d, ctlb_q, ctlb_d;
    logic [2:0]  mask_q, mask_d;
    logic        ext_clock_in_en_q, ext_clock_in_en_d, as_q, as_d, tsm_q, tsm_d;
    logic        apsr_d, spsr_d, wave_d;
    t2r_dir_type dir_q, dir_d;
    logic [4:0]  busy, load;
    logic [7:0]  held [5];
    logic [2:0]  flags;
    logic [2:0]  clr_f;
    logic [2:0]  wgm;
    logic [7:0]  top;
    logic        pc, run, match_a, match_b, ovf_ev;
    logic [7:0]  rd_d;

    // Timer ticks on every I/O clock or on each oscillator rising edge
    assign osc_tick = osc_s2_q && !osc_s3_q;
    assign tick     = as_q ? osc_tick : 1'b1;

    // Five holding cells: counter, compare A/B, control A/B
    logic [4:0] cap;
    logic [7:0] cap_data [5];
    assign cap[4] = wr_cnt && as_q;
    assign cap[3] = wr_cmpa && as_q;
    assign cap[2] = wr_cmpb && as_q;
    assign cap[1] = wr_ctla && as_q;
    assign cap[0] = wr_ctlb && as_q;
    assign cap_data[4] = wd;
    assign cap_data[3] = wd;
    assign cap_data[2] = wd;
    assign cap_data[1] = wd & `T2R_CTRL_A_MASK;
    assign cap_data[0] = wd & `T2R_CTRL_B_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_hold
            t2r_hold_cell #(.WIDTH(8)) u_hold (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .capture  (cap[gi]),
                .wdata    (cap_data[gi]),
                .commit   (osc_tick),
                .busy_q   (busy[gi]),
                .held_q   (held[gi]),
                .load     (load[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Counter, compare and overflow events
    // ----------------------------------------
    always_comb begin
        wgm     = {ctlb_q[3], ctla_q[1:0]};
        pc      = wgm[0] && !wgm[1];
        top     = (wgm == 3'd2 || wgm == 3'd5 || wgm == 3'd7) ? cmpa_q : `T2R_MAX;
        run     = (ctlb_q[2:0] != 3'd0) && !async_prescaler_reset_q && tick;
        match_a = run && (cnt_q == cmpa_q);
        match_b = run && (cnt_q == cmpb_q);
        // Phase-correct flags at the turn at bottom, others at MAX or TOP
        if (pc) begin
            ovf_ev = run && (dir_q == T2R_DOWN) && (cnt_q == `T2R_BOTTOM);
        end else begin
            ovf_ev = run && (cnt_q == ((wgm == 3'd7) ? top : `T2R_MAX));
        end
    end

    // Write-one clear or vector acknowledge
    assign clr_f[2] = (wr_flags && wd[`T2R_BIT_CMP_B]) || irq_ack.cmp_b;
    assign clr_f[1] = (wr_flags && wd[`T2R_BIT_CMP_A]) || irq_ack.cmp_a;
    assign clr_f[0] = (wr_flags && wd[`T2R_BIT_OVF]) || irq_ack.ovf;

    t2r_flag_cell u_flag_b (.core_clk(core_clk), .rst_n(rst_n), .set(match_b),
                            .clr(clr_f[2]), .flag_q(flags[2]));
    t2r_flag_cell u_flag_a (.core_clk(core_clk), .rst_n(rst_n), .set(match_a),
                            .clr(clr_f[1]), .flag_q(flags[1]));
    t2r_flag_cell u_flag_o (.core_clk(core_clk), .rst_n(rst_n), .set(ovf_ev),
                            .clr(clr_f[0]), .flag_q(flags[0]));

    // ----------------------------------------
    // Next-state of registers
    // ----------------------------------------
    always_comb begin
        cnt_d  = cnt_q;
        dir_d  = dir_q;
        cmpa_d = load[3] ? held[3] : cmpa_q;
        cmpb_d = load[2] ? held[2] : cmpb_q;
        ctla_d = load[1] ? held[1] : ctla_q;
        ctlb_d = load[0] ? held[0] : ctlb_q;
        mask_d = wr_mask ? wd[2:0] : mask_q;
        wave_d = compare_b_wave_pin_q;
        // Counting: phase-correct turns at TOP and bottom
        if (run) begin
            if (pc) begin
                if (dir_q == T2R_UP) begin
                    dir_d = (cnt_q == top) ? T2R_DOWN : T2R_UP;
                    cnt_d = (cnt_q == top) ? cnt_q - 8'h01 : cnt_q + 8'h01;
                end else begin
                    dir_d = (cnt_q == `T2R_BOTTOM) ? T2R_UP : T2R_DOWN;
                    cnt_d = (cnt_q == `T2R_BOTTOM) ? cnt_q + 8'h01 : cnt_q - 8'h01;
                end
            end else begin
                dir_d = T2R_UP;
                cnt_d = (cnt_q == top) ? `T2R_BOTTOM : cnt_q + 8'h01;
            end
        end
        if (load[4]) begin
            cnt_d = held[4];
        end
        // Synchronous mode writes land at once
        if (!as_q) begin
            if (wr_cnt) cnt_d = wd;
            if (wr_cmpa) cmpa_d = wd;
            if (wr_cmpb) cmpb_d = wd;
            if (wr_ctla) ctla_d = wd & `T2R_CTRL_A_MASK;
            if (wr_ctlb) ctlb_d = wd & `T2R_CTRL_B_MASK;
        end
        // Compare-B pin: forced strobe acts like a match outside PWM
        if (match_b || (wr_ctlb && wd[`T2R_BIT_FOC_B] && !wgm[0])) begin
            unique case (ctla_q[5:4])
                2'b01:   wave_d = !compare_b_wave_pin_q;
                2'b10:   wave_d = 1'b0;
                2'b11:   wave_d = 1'b1;
                2'b00:   wave_d = compare_b_wave_pin_q;
            endcase
        end
        // Only the clock-source bits are writable here; busy bits are hardware's
        ext_clock_in_en_d = wr_async ? wd[`T2R_BIT_EXT_CLOCK_IN_EN] : ext_clock_in_en_q;
        as_d    = wr_async ? wd[`T2R_BIT_AS] : as_q;
        // Prescaler reset control
        tsm_d  = wr_psync ? wd[`T2R_BIT_TSM] : tsm_q;
        apsr_d = async_prescaler_reset_q;
        spsr_d = sync_prescaler_reset_q;
        if (!tsm_q) begin
            spsr_d = 1'b0;
            if (!as_q || osc_tick) begin
                apsr_d = 1'b0;
            end
        end
        if (wr_psync) begin
            spsr_d = spsr_d || wd[`T2R_BIT_SYNC_PRESCALER_RESET];
            apsr_d = apsr_d || wd[`T2R_BIT_ASYNC_PRESCALER_RESET];
            if (!wd[`T2R_BIT_TSM]) begin
                spsr_d = tsm_q ? 1'b0 : spsr_d;
                apsr_d = tsm_q ? 1'b0 : apsr_d;
            end
        end
        // Registered read data; unmapped reads return zero
        rd_d = 8'h00;
        if (bus_req.rd && io_ok) begin
            unique case (eff_addr)
                `T2R_OFS_FLAGS:  rd_d = {5'h00, flags};
                `T2R_OFS_PSYNC:  rd_d = {tsm_q, 5'h00, async_prescaler_reset_q,
                                         sync_prescaler_reset_q};
                `T2R_OFS_MASK:   rd_d = {5'h00, mask_q};
                `T2R_OFS_CTRL_A: rd_d = ctla_q;
                `T2R_OFS_CTRL_B: rd_d = ctlb_q;
                `T2R_OFS_CNT:    rd_d = cnt_q;
                `T2R_OFS_CMP_A:  rd_d = cmpa_q;
                `T2R_OFS_CMP_B:  rd_d = cmpb_q;
                `T2R_OFS_ASYNC:  rd_d = {1'b0, ext_clock_in_en_q, as_q, busy};
                default:         rd_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Register update
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q                   <= `T2R_RST_VAL;
            cmpa_q                  <= `T2R_RST_VAL;
            cmpb_q                  <= `T2R_RST_VAL;
            ctla_q                  <= `T2R_RST_VAL;
            ctlb_q                  <= `T2R_RST_VAL;
            mask_q                  <= 3'h0;
            dir_q                   <= T2R_UP;
            ext_clock_in_en_q                 <= 1'b0;
            as_q                    <= 1'b0;
            tsm_q                   <= 1'b0;
            async_prescaler_reset_q <= 1'b0;
            sync_prescaler_reset_q  <= 1'b0;
            compare_b_wave_pin_q    <= 1'b0;
            bus_rdata_q             <= 8'h00;
            irq_req_q               <= '0;
            ext_clk_buf_en_q        <= 1'b0;
            xtal_osc_run_q          <= 1'b0;
        end else begin
            cnt_q                   <= cnt_d;
            cmpa_q                  <= cmpa_d;
            cmpb_q                  <= cmpb_d;
            ctla_q                  <= ctla_d;
            ctlb_q                  <= ctlb_d;
            mask_q                  <= mask_d;
            dir_q                   <= dir_d;
            ext_clock_in_en_q                 <= ext_clock_in_en_d;
            as_q                    <= as_d;
            tsm_q                   <= tsm_d;
            async_prescaler_reset_q <= apsr_d;
            sync_prescaler_reset_q  <= spsr_d;
            compare_b_wave_pin_q    <= wave_d;
            bus_rdata_q             <= rd_d;
            irq_req_q.cmp_b         <= flags[2] && mask_q[2] && gie;
            irq_req_q.cmp_a         <= flags[1] && mask_q[1] && gie;
            irq_req_q.ovf           <= flags[0] && mask_q[0] && gie;
            ext_clk_buf_en_q        <= ext_clock_in_en_q && as_q;
            xtal_osc_run_q          <= !ext_clock_in_en_q && as_q;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cmp_b_set_a: assert property (match_b |=> flags[2])
        else $error("compare B match did not set its flag");
    cmp_a_set_a: assert property (match_a |=> flags[1])
        else $error("compare A match did not set its flag");
    ovf_set_a: assert property (ovf_ev |=> flags[0])
        else $error("overflow event did not set its flag");
    ack_clear_a: assert property (irq_ack.ovf && !ovf_ev |=> !flags[0])
        else $error("acknowledge did not clear overflow flag");
    w1c_zero_a: assert property (wr_flags && wd[2:0] == 3'h0 && irq_ack == '0
                                 |=> (flags & $past(flags)) == $past(flags))
        else $error("writing zero cleared a flag");
    irq_gate_a: assert property (!gie |=> irq_req_q == '0)
        else $error("request raised with global enable low");
    irq_mask_a: assert property (!mask_q[1] && !mask_d[1] |=> ##1 !irq_req_q.cmp_a)
        else $error("compare A request raised while masked");
    ovf_irq_a: assert property (flags[0] && mask_q[0] && gie |=> irq_req_q.ovf)
        else $error("overflow request missing");
    cnt_busy_a: assert property (cap[4] |=> busy[4] && held[4] == $past(wd))
        else $error("async counter write did not set busy");
    cmpb_commit_a: assert property (busy[2] && osc_tick && !cap[2]
                                    |=> !busy[2] && cmpb_q == $past(held[2]))
        else $error("compare B transfer incomplete");
    tsm_hold_a: assert property (tsm_q && sync_prescaler_reset_q && !wr_psync
                                 |=> sync_prescaler_reset_q)
        else $error("prescaler reset dropped in hold mode");
    psync_clear_a: assert property (!tsm_q && !wr_psync |=> !sync_prescaler_reset_q)
        else $error("sync prescaler reset did not self-clear");
    extbuf_a: assert property (ext_clock_in_en_q && as_q |=> ext_clk_buf_en_q && !xtal_osc_run_q)
        else $error("external buffer not enabled");

    async_write_c: cover property (cap[3] ##[1:200] load[3]);
    pwm_turn_c: cover property (pc && ovf_ev);
    ack_c: cover property (irq_req_q.cmp_b ##1 irq_ack.cmp_b);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the timer-2 register block
// Assumes: Registers reached by one-cycle wr/rd strobes; reads answer one cycle later
// Notes:   Inputs change on the falling edge; random values from a bench LFSR
`timescale 1ns/1ps
`default_nettype none
`include "t2r_map.svh"
module tb_top
    import t2r_pkg::*;
;
    localparam logic [7:0] RST_REGS [5] = '{`T2R_OFS_FLAGS, `T2R_OFS_PSYNC, `T2R_OFS_MASK,
                                            `T2R_OFS_CMP_B, `T2R_OFS_ASYNC};
    localparam logic [7:0] ASY_REGS [5] = '{`T2R_OFS_CNT, `T2R_OFS_CMP_A, `T2R_OFS_CMP_B,
                                            `T2R_OFS_CTRL_A, `T2R_OFS_CTRL_B};
    logic            core_clk;
    logic            rst_n;
    t2r_bus_req_type bus_req;
    logic            gie;
    t2r_irq_type     irq_ack;
    logic            osc_input_pin;
    logic [7:0]      bus_rdata_q;
    t2r_irq_type     irq_req_q;
    logic            compare_b_wave_pin_q;
    logic            ext_clk_buf_en_q;
    logic            xtal_osc_run_q;
    logic            async_prescaler_reset_q;
    logic            sync_prescaler_reset_q;
    int              num_errors;
    int              num_checks;
    int              cycles = 0;
    logic [31:0]     lfsr;
    logic [7:0]      val;

    t2r_timer2_regs DUT (
        .core_clk                (core_clk),
        .rst_n                   (rst_n),
        .bus_req                 (bus_req),
        .gie                     (gie),
        .irq_ack                 (irq_ack),
        .osc_input_pin           (osc_input_pin),
        .bus_rdata_q             (bus_rdata_q),
        .irq_req_q               (irq_req_q),
        .compare_b_wave_pin_q    (compare_b_wave_pin_q),
        .ext_clk_buf_en_q        (ext_clk_buf_en_q),
        .xtal_osc_run_q          (xtal_osc_run_q),
        .async_prescaler_reset_q (async_prescaler_reset_q),
        .sync_prescaler_reset_q  (sync_prescaler_reset_q)
    );

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Whole run needs well under 2000 cycles; the ceiling leaves ample slack
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Request level expected from flags, mask and global enable
    function automatic logic [7:0] exp_irq(input logic [2:0] f, input logic [2:0] m,
                                           input logic g);
        return g ? {5'h00, f & m} : 8'h00;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes last one cycle, so back-to-back calls never touch one signal twice at an edge
    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        bus_req = '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: d};
        @(negedge core_clk);
        bus_req = '0;
    endtask
    task automatic rd_chk(input logic io, input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        bus_req = '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        bus_req = '0;
        check(bus_rdata_q, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        gie = 1'b0;
        irq_ack = '0;
        osc_input_pin = 1'b0;
        lfsr = 32'h0000DBD9;
        num_errors = 0;
        num_checks = 0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(1'b0, RST_REGS[i], `T2R_RST_VAL);
        rd_chk(1'b1, 8'h50, 8'h00);
        // Prescaler resets: self-clear, held by sync mode, dropped together on exit
        wr(1'b1, 8'h23, 8'h01);
        check({7'h00, sync_prescaler_reset_q}, 8'h01);
        @(negedge core_clk);
        check({7'h00, sync_prescaler_reset_q}, 8'h00);
        wr(1'b0, `T2R_OFS_PSYNC, 8'h83);
        repeat (3) @(negedge core_clk);
        check({6'h00, async_prescaler_reset_q, sync_prescaler_reset_q}, 8'h03);
        rd_chk(1'b0, `T2R_OFS_PSYNC, 8'h83);
        wr(1'b0, `T2R_OFS_PSYNC, 8'h03);
        repeat (2) @(negedge core_clk);
        rd_chk(1'b1, 8'h23, 8'h00);
        // Free-run past a full wrap so every match and the overflow occur
        val = lfsr[7:0];
        wr(1'b0, `T2R_OFS_CMP_B, val);
        rd_chk(1'b0, `T2R_OFS_CMP_B, val);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h01);
        repeat (300) @(negedge core_clk);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h00);
        // 302 ticks from zero in normal mode wrap once and stop at 0x2E
        rd_chk(1'b0, `T2R_OFS_CNT, 8'h2E);
        rd_chk(1'b1, 8'h17, 8'h07);
        for (int i = 0; i < 8; i++) begin
            lfsr = next_lfsr(lfsr);
            gie = lfsr[3] | (i == 7);
            wr(1'b0, `T2R_OFS_MASK, {5'h00, i[2:0]});
            @(negedge core_clk);
            check({5'h00, irq_req_q}, exp_irq(3'h7, i[2:0], gie));
        end
        // Writing zero keeps flags, writing one clears only that flag
        wr(1'b1, 8'h17, 8'h00);
        rd_chk(1'b0, `T2R_OFS_FLAGS, 8'h07);
        wr(1'b0, `T2R_OFS_FLAGS, 8'h02);
        rd_chk(1'b0, `T2R_OFS_FLAGS, 8'h05);
        irq_ack = '{cmp_b: 1'b1, cmp_a: 1'b0, ovf: 1'b1};
        @(negedge core_clk);
        irq_ack = '0;
        rd_chk(1'b0, `T2R_OFS_FLAGS, 8'h00);
        check({5'h00, irq_req_q}, 8'h00);
        // Forced compare-B strobe outside PWM: toggle mode, then clear mode
        wr(1'b0, `T2R_OFS_CTRL_A, 8'h10);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h40);
        check({7'h00, compare_b_wave_pin_q}, 8'h01);
        wr(1'b0, `T2R_OFS_CTRL_A, 8'h20);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h40);
        check({7'h00, compare_b_wave_pin_q}, 8'h00);
        // Phase-correct run turns at TOP and never reaches bottom, so no overflow flag
        wr(1'b0, `T2R_OFS_CNT, 8'h01);
        wr(1'b0, `T2R_OFS_CTRL_A, 8'h01);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h01);
        repeat (300) @(negedge core_clk);
        wr(1'b0, `T2R_OFS_CTRL_B, 8'h00);
        rd_chk(1'b0, `T2R_OFS_CNT, 8'hCF);
        rd_chk(1'b0, `T2R_OFS_FLAGS, 8'h04);
        // Clock source: external input chosen before async mode
        wr(1'b0, `T2R_OFS_ASYNC, 8'h40);
        @(negedge core_clk);
        check({6'h00, ext_clk_buf_en_q, xtal_osc_run_q}, 8'h00);
        wr(1'b0, `T2R_OFS_ASYNC, 8'h60);
        @(negedge core_clk);
        check({6'h00, ext_clk_buf_en_q, xtal_osc_run_q}, 8'h02);
        // Leave async mode and clear the external clock bit in one write, then re-enter async mode
        wr(1'b0, `T2R_OFS_ASYNC, 8'h00);
        wr(1'b0, `T2R_OFS_ASYNC, 8'h20);
        @(negedge core_clk);
        check({6'h00, ext_clk_buf_en_q, xtal_osc_run_q}, 8'h01);
        // Each async register written once while idle, so no write lands on a busy one
        val = lfsr[15:8];
        for (int i = 0; i < 5; i++) wr(1'b0, ASY_REGS[i], (i == 2) ? val : 8'h00);
        rd_chk(1'b0, `T2R_OFS_ASYNC, 8'h3F);
        osc_input_pin = 1'b1;
        repeat (6) @(negedge core_clk);
        rd_chk(1'b0, `T2R_OFS_ASYNC, 8'h20);
        rd_chk(1'b0, `T2R_OFS_CMP_B, val);
        wr(1'b0, `T2R_OFS_ASYNC, 8'h3F);
        rd_chk(1'b0, `T2R_OFS_ASYNC, 8'h20);
        osc_input_pin = 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire
